// ==== core/cbt_pkg.sv ====
// Contract
// - Extended mask bit one compares its identifier bit; zero ignores it.
// - A stored message sets its buffer's full flag; all clear at reset.
// - Full flags are clear-only; software clears, only hardware sets.
// - A store into a full buffer sets its overflow flag; software clears.
// - Control bit 7 makes the buffer transmit when one, receive when zero.
// - Upper control byte drives the odd buffer, same layout as lower byte.
// - Setting send request starts sending; hardware clears it on success.
// - Software clearing a set send request asks for an abort.
// - Aborted, arbitration-lost and bus-error outcome flags are read-only.
// - Outcome flags clear whenever the send request becomes set.
// - Auto-remote enable plus a matching remote frame sets send request.
// - Two-bit priority, 11 highest down to 00 lowest.
// - Identifier word holds standard identifier in 12-2; 15-13 read zero.
// - Identifier word bit 0 selects extended or standard format.
// - Identifier word bit 1 marks a remote transmission request.
// - Buffer words live in DMA memory, outside the register space.
// - Standard mask bit one compares its identifier bit; zero ignores it.
// - Stored message status word records accepting filter number in 12-8.
package cbt_pkg;
    localparam logic [7:0] OFF_MASK_SID = 8'h00;
    localparam logic [7:0] OFF_MASK_EID = 8'h04;
    localparam logic [7:0] OFF_FULL_LO = 8'h08;
    localparam logic [7:0] OFF_FULL_HI = 8'h0C;
    localparam logic [7:0] OFF_OVF_LO = 8'h10;
    localparam logic [7:0] OFF_OVF_HI = 8'h14;
    localparam logic [7:0] OFF_CTRL0 = 8'h18;
    localparam logic [7:0] OFF_TX_STAT = 8'h28;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] MASK_SID_RMASK = 16'hFFEB;
    localparam int CTL_DIR = 7;
    localparam int CTL_ABT = 6;
    localparam int CTL_LARB = 5;
    localparam int CTL_ERR = 4;
    localparam int CTL_REQ = 3;
    localparam int CTL_RTR = 2;
    localparam int MASK_SID_LSB = 5;
    localparam int SIDW_SID_LSB = 2;
    localparam int SIDW_SRR = 1;
    localparam int SIDW_IDE = 0;
    localparam int STAT_FILT_LSB = 8;
    localparam int NUM_CTL_BUF = 8;

    typedef enum logic [1:0] {
        CBT_RES_OK = 2'b00,
        CBT_RES_ARB = 2'b01,
        CBT_RES_ERR = 2'b10,
        CBT_RES_ABT = 2'b11
    } cbt_tx_res_t;

    typedef struct packed {
        logic valid;
        logic [4:0] buf_idx;
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic [28:0] filt_id;
        logic [4:0] filt_num;
    } cbt_rx_evt_t;

    typedef struct packed {
        logic valid;
        logic [4:0] buf_idx;
        logic [15:0] sid_word;
        logic [15:0] stat_word;
    } cbt_dma_wr_t;

    typedef struct packed {
        logic valid;
        logic [2:0] buf_idx;
        cbt_tx_res_t res;
    } cbt_tx_done_t;

    typedef struct packed {
        logic valid;
        logic [2:0] buf_idx;
    } cbt_tx_offer_t;
endpackage

// ==== core/cbt_id_match.sv ====
`timescale 1ns/100ps
module cbt_id_match (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [28:0] id,
    input wire logic [28:0] filt_id,
    input wire logic [28:0] mask,
    input wire logic ide,
    output logic hit
);
    logic [28:0] diff;

    always_comb
    begin
        diff = (id ^ filt_id) & mask;
        // Standard frames carry no extended bits to compare
        if (!ide)
        begin
            diff[17:0] = 18'h00000;
        end
        hit = (diff == 29'h00000000);
    end

    masked_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ide && ((id ^ filt_id) & mask) != 29'h00000000) |-> !hit)
        else $error("masked identifier bit mismatch still hit");
endmodule // cbt_id_match

// ==== core/cbt_tx_arb.sv ====
`timescale 1ns/100ps
module cbt_tx_arb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] pend,
    input wire logic [15:0] pri,
    output logic found,
    output logic [2:0] idx
);
    logic [1:0] best;

    always_comb
    begin
        found = 1'b0;
        idx = 3'h0;
        best = 2'h0;
        // Ascending scan with >= lets the higher buffer win ties
        for (int i = 0; i < 8; i++)
        begin
            if (pend[i] && (!found || pri[2*i +: 2] >= best))
            begin
                found = 1'b1;
                idx = 3'(i);
                best = pri[2*i +: 2];
            end
        end
    end

    pick_highest_a: assert property (@(posedge pclk) disable iff (!presetn)
        found |-> pend[idx] && (((pend >> idx) >> 1) == 8'h00 ||
        pri[2*idx +: 2] > pri[2*idx + 2 +: 2] || idx == 3'h7
        || !pend[idx + 3'h1]))
        else $error("offered buffer is not the best pending one");
endmodule // cbt_tx_arb

// ==== core/cbt_buffer_ctrl.sv ====
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module cbt_buffer_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cbt_pkg::cbt_rx_evt_t rx_evt,
    input wire cbt_pkg::cbt_tx_done_t tx_done,
    output cbt_pkg::cbt_dma_wr_t dma_wr,
    output cbt_pkg::cbt_tx_offer_t tx_offer,
    output logic [7:0] tx_abort
);
    logic [15:0] mask_sid_q, mask_sid_d;
    logic [15:0] mask_eid_q, mask_eid_d;
    logic [31:0] full_q, full_d;
    logic [31:0] ovf_q, ovf_d;
    logic [7:0] ctrl_q [8];
    logic [7:0] ctrl_d [8];
    logic [7:0] abort_q, abort_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    cbt_pkg::cbt_dma_wr_t dma_q, dma_d;
    cbt_pkg::cbt_tx_offer_t offer_q, offer_d;

    logic [7:0] addr;
    logic mapped;
    logic commit;
    logic wr_commit;
    logic [15:0] clr16;
    logic [28:0] mask29;
    logic hit;
    logic ctl_buf;
    logic consumed;
    logic store;
    logic store_ok;
    logic store_ovf;
    logic [31:0] sel32;
    logic [7:0] rtr_hit;
    logic [7:0] pend;
    logic [15:0] pri;
    logic arb_found;
    logic [2:0] arb_idx;

    assign addr = paddr[7:0];
    assign mapped = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
        (addr <= cbt_pkg::OFF_TX_STAT);
    // Writes take effect only at the edge that ends the access; read data is captured one edge earlier
    assign commit = psel && penable && pready_q;
    assign wr_commit = commit && pwrite && mapped;
    // Clear-only bits: a zero written in an enabled lane clears
    assign clr16 = {{8{pstrb[1]}}, {8{pstrb[0]}}} & ~pwdata[15:0];
    assign mask29 = {mask_sid_q[15:cbt_pkg::MASK_SID_LSB], mask_sid_q[1:0],
        mask_eid_q};
    assign sel32 = 32'h00000001 << rx_evt.buf_idx;
    assign ctl_buf = (rx_evt.buf_idx < 5'h08);

    cbt_id_match u_match (
        .pclk(pclk),
        .presetn(presetn),
        .id(rx_evt.id),
        .filt_id(rx_evt.filt_id),
        .mask(mask29),
        .ide(rx_evt.ide),
        .hit(hit)
    );

    always_comb
    begin
        rtr_hit = 8'h00;
        consumed = 1'b0;
        if (rx_evt.valid && hit && ctl_buf)
        begin
            // transmit buffers never take received data
            consumed = ctrl_q[rx_evt.buf_idx[2:0]][cbt_pkg::CTL_DIR];
            if (rx_evt.rtr && consumed &&
                ctrl_q[rx_evt.buf_idx[2:0]][cbt_pkg::CTL_RTR])
            begin
                rtr_hit[rx_evt.buf_idx[2:0]] = 1'b1;
            end
        end
        store = rx_evt.valid && hit && !consumed;
        store_ok = store && !full_q[rx_evt.buf_idx];
        store_ovf = store && full_q[rx_evt.buf_idx];
    end

    always_comb
    begin
        mask_sid_d = mask_sid_q;
        mask_eid_d = mask_eid_q;
        full_d = full_q;
        ovf_d = ovf_q;
        if (wr_commit && addr == cbt_pkg::OFF_MASK_SID)
        begin
            mask_sid_d = pwdata[15:0] & cbt_pkg::MASK_SID_RMASK;
        end
        if (wr_commit && addr == cbt_pkg::OFF_MASK_EID)
        begin
            mask_eid_d = pwdata[15:0];
        end
        if (wr_commit && addr == cbt_pkg::OFF_FULL_LO)
        begin
            full_d[15:0] = full_d[15:0] & ~clr16;
        end
        if (wr_commit && addr == cbt_pkg::OFF_FULL_HI)
        begin
            full_d[31:16] = full_d[31:16] & ~clr16;
        end
        if (wr_commit && addr == cbt_pkg::OFF_OVF_LO)
        begin
            ovf_d[15:0] = ovf_d[15:0] & ~clr16;
        end
        if (wr_commit && addr == cbt_pkg::OFF_OVF_HI)
        begin
            ovf_d[31:16] = ovf_d[31:16] & ~clr16;
        end
        if (store_ok)
        begin
            full_d = full_d | sel32;
        end
        if (store_ovf)
        begin
            ovf_d = ovf_d | sel32;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_sid_q <= cbt_pkg::RST_WORD;
            mask_eid_q <= cbt_pkg::RST_WORD;
            full_q <= {cbt_pkg::RST_WORD, cbt_pkg::RST_WORD};
            ovf_q <= {cbt_pkg::RST_WORD, cbt_pkg::RST_WORD};
        end
        else
        begin
            mask_sid_q <= mask_sid_d;
            mask_eid_q <= mask_eid_d;
            full_q <= full_d;
            ovf_q <= ovf_d;
        end
    end

    generate
        for (genvar i = 0; i < cbt_pkg::NUM_CTL_BUF; i++)
        begin : g_buf
            localparam logic [7:0] CADDR = cbt_pkg::OFF_CTRL0 + 8'(4 * (i / 2));
            logic sw_wr;
            logic [7:0] wb;
            logic done;

            assign sw_wr = wr_commit && addr == CADDR && pstrb[i % 2];
            assign wb = pwdata[8 * (i % 2) +: 8];
            assign done = tx_done.valid && tx_done.buf_idx == 3'(i);

            always_comb
            begin
                ctrl_d[i] = ctrl_q[i];
                abort_d[i] = 1'b0;
                if (done && (tx_done.res == cbt_pkg::CBT_RES_OK ||
                    tx_done.res == cbt_pkg::CBT_RES_ABT))
                begin
                    ctrl_d[i][cbt_pkg::CTL_REQ] = 1'b0;
                end
                if (sw_wr)
                begin
                    ctrl_d[i][cbt_pkg::CTL_DIR] = wb[7];
                    ctrl_d[i][cbt_pkg::CTL_REQ] = wb[3];
                    ctrl_d[i][cbt_pkg::CTL_RTR] = wb[2];
                    ctrl_d[i][1:0] = wb[1:0];
                end
                abort_d[i] = sw_wr && ctrl_q[i][cbt_pkg::CTL_REQ] && !wb[3];
                if (rtr_hit[i])
                begin
                    ctrl_d[i][cbt_pkg::CTL_REQ] = 1'b1;
                end
                if (ctrl_d[i][cbt_pkg::CTL_REQ] && !ctrl_q[i][cbt_pkg::CTL_REQ])
                begin
                    ctrl_d[i][6:4] = 3'b000;
                end
                if (done)
                begin
                    unique case (tx_done.res)
                        cbt_pkg::CBT_RES_OK: ;
                        cbt_pkg::CBT_RES_ARB: ctrl_d[i][cbt_pkg::CTL_LARB] = 1'b1;
                        cbt_pkg::CBT_RES_ERR: ctrl_d[i][cbt_pkg::CTL_ERR] = 1'b1;
                        cbt_pkg::CBT_RES_ABT: ctrl_d[i][cbt_pkg::CTL_ABT] = 1'b1;
                    endcase
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ctrl_q[i] <= 8'h00;
                    abort_q[i] <= 1'b0;
                end
                else
                begin
                    ctrl_q[i] <= ctrl_d[i];
                    abort_q[i] <= abort_d[i];
                end
            end

            assign pend[i] = ctrl_q[i][cbt_pkg::CTL_REQ] &&
                ctrl_q[i][cbt_pkg::CTL_DIR];
            assign pri[2*i +: 2] = ctrl_q[i][1:0];

            req_cleared_a: assert property (@(posedge pclk) disable iff (!presetn)
                (done && tx_done.res == cbt_pkg::CBT_RES_OK && !sw_wr
                && !rtr_hit[i]) |=> !ctrl_q[i][cbt_pkg::CTL_REQ])
                else $error("send request not cleared after success");
            abort_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
                (sw_wr && ctrl_q[i][cbt_pkg::CTL_REQ] && !wb[3])
                |=> tx_abort[i] ##1 !tx_abort[i])
                else $error("abort pulse missing after request cleared");
            flags_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
                $rose(ctrl_q[i][cbt_pkg::CTL_REQ]) && !$past(done)
                |-> ctrl_q[i][6:4] == 3'b000)
                else $error("outcome flags survived a new request");
            remote_set_a: assert property (@(posedge pclk) disable iff (!presetn)
                rtr_hit[i] |=> ctrl_q[i][cbt_pkg::CTL_REQ])
                else $error("remote request did not set send request");
        end
    endgenerate

    cbt_tx_arb u_arb (
        .pclk(pclk),
        .presetn(presetn),
        .pend(pend),
        .pri(pri),
        .found(arb_found),
        .idx(arb_idx)
    );

    always_comb
    begin
        offer_d.valid = arb_found;
        offer_d.buf_idx = arb_idx;
        // buffer words go out to DMA memory
        dma_d.valid = store_ok;
        dma_d.buf_idx = rx_evt.buf_idx;
        dma_d.sid_word = {3'b000, rx_evt.id[28:18], rx_evt.rtr, rx_evt.ide};
        dma_d.stat_word = {3'b000, rx_evt.filt_num, 8'h00};
    end

    // Single wait state keeps pready and prdata registered
    always_comb
    begin
        pready_d = psel && penable && !pready_q;
        pslverr_d = pready_d && !mapped;
        prdata_d = prdata_q;
        if (pready_d)
        begin
            prdata_d = 32'h00000000;
            if (!pwrite)
            begin
                unique case (addr)
                    cbt_pkg::OFF_MASK_SID: prdata_d[15:0] = mask_sid_q;
                    cbt_pkg::OFF_MASK_EID: prdata_d[15:0] = mask_eid_q;
                    cbt_pkg::OFF_FULL_LO: prdata_d[15:0] = full_q[15:0];
                    cbt_pkg::OFF_FULL_HI: prdata_d[15:0] = full_q[31:16];
                    cbt_pkg::OFF_OVF_LO: prdata_d[15:0] = ovf_q[15:0];
                    cbt_pkg::OFF_OVF_HI: prdata_d[15:0] = ovf_q[31:16];
                    8'h18: prdata_d[15:0] = {ctrl_q[1], ctrl_q[0]};
                    8'h1C: prdata_d[15:0] = {ctrl_q[3], ctrl_q[2]};
                    8'h20: prdata_d[15:0] = {ctrl_q[5], ctrl_q[4]};
                    8'h24: prdata_d[15:0] = {ctrl_q[7], ctrl_q[6]};
                    cbt_pkg::OFF_TX_STAT: prdata_d[3:0] = {offer_q.valid,
                        offer_q.buf_idx};
                    default: prdata_d = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            dma_q <= '0;
            offer_q <= '0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            dma_q <= dma_d;
            offer_q <= offer_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dma_wr = dma_q;
    assign tx_offer = offer_q;
    assign tx_abort = abort_q;

    sequence apb_setup_s;
        psel && penable && !pready;
    endsequence
    sequence apb_done_s;
        pready ##1 !pready;
    endsequence
    apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_setup_s |=> apb_done_s)
        else $error("access phase did not end after one wait state");
    full_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        store_ok |=> full_q[$past(rx_evt.buf_idx)] && dma_wr.valid)
        else $error("store did not set full flag and write buffer");
    full_only_hw_a: assert property (@(posedge pclk) disable iff (!presetn)
        (full_q & ~$past(full_q)) != 32'h00000000 |-> $past(store_ok))
        else $error("full flag set without a store");
    ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        store_ovf |=> ovf_q[$past(rx_evt.buf_idx)] && !dma_wr.valid
        && full_q[$past(rx_evt.buf_idx)])
        else $error("overflow not flagged or buffer overwritten");
    sid_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        dma_wr.valid |-> dma_wr.sid_word[15:13] == 3'b000
        && dma_wr.stat_word[7:0] == 8'h00)
        else $error("reserved identifier word bits not zero");
endmodule // cbt_buffer_ctrl

// ==== testbench/cbt_can_node.sv ====
`timescale 1ns/100ps
module cbt_can_node (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rx_go,
    input wire cbt_pkg::cbt_rx_evt_t rx_cmd,
    input wire logic tx_go,
    input wire cbt_pkg::cbt_tx_res_t tx_res,
    input wire cbt_pkg::cbt_tx_offer_t tx_offer,
    output cbt_pkg::cbt_rx_evt_t rx_evt,
    output cbt_pkg::cbt_tx_done_t tx_done
);
    logic armed_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_evt <= '0;
            tx_done <= '0;
            armed_q <= 1'b0;
        end
        else
        begin
            // Idle fields toggle so stale values never look valid
            rx_evt <= rx_go ? rx_cmd : ~rx_cmd;
            tx_done.valid <= 1'b0;
            if (tx_go)
                armed_q <= 1'b1;
            else if (armed_q && tx_offer.valid)
            begin
                tx_done <= {1'b1, tx_offer.buf_idx, tx_res};
                armed_q <= 1'b0;
            end
        end
    end
endmodule // cbt_can_node

// ==== testbench/can_buffer_status_and_tx_control_tb_top.sv ====
`timescale 1ns/100ps
module can_buffer_status_and_tx_control_tb_top;
    localparam logic [28:0] FILT = 29'h0ABCDE12;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic rx_go, tx_go, e;
    logic [7:0] tx_abort, abort_seen;
    cbt_pkg::cbt_rx_evt_t rx_cmd, rx_evt;
    cbt_pkg::cbt_tx_res_t tx_res;
    cbt_pkg::cbt_tx_done_t tx_done;
    cbt_pkg::cbt_tx_offer_t tx_offer;
    cbt_pkg::cbt_dma_wr_t dma_wr, dma_last;
    int num_errors = 0;
    int checked = 0;

    cbt_buffer_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_evt(rx_evt), .tx_done(tx_done), .dma_wr(dma_wr),
        .tx_offer(tx_offer), .tx_abort(tx_abort));
    cbt_can_node node (.pclk(pclk), .presetn(presetn), .rx_go(rx_go),
        .rx_cmd(rx_cmd), .tx_go(tx_go), .tx_res(tx_res),
        .tx_offer(tx_offer), .rx_evt(rx_evt), .tx_done(tx_done));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (dma_wr.valid === 1'b1)
            dma_last <= dma_wr;
        if (!presetn)
            abort_seen <= '0;
        else if (tx_abort !== 8'h00)
            abort_seen <= tx_abort;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        checked++;
        if (g !== x)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h0, a};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A stuck slave ends the run here rather than at the watchdog
        if (n >= 20)
        begin
            chk("pready", 1, 0);
            final_report();
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [15:0] x);
        apb(1'b0, a, 16'h0000);
        chk(nm, {16'h0000, x}, r);
    endtask
    task automatic rx(input logic [4:0] b, input logic [28:0] id,
                      input logic ide, input logic rtr, input logic [4:0] fn);
        @(posedge pclk);
        rx_cmd <= {1'b1, b, id, ide, rtr, FILT, fn};
        rx_go <= 1'b1;
        @(posedge pclk);
        rx_go <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic txo(input cbt_pkg::cbt_tx_res_t res);
        tx_res <= res;
        tx_go <= 1'b1;
        @(posedge pclk);
        tx_go <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    task automatic t_reset();
        rd("full_lo", cbt_pkg::OFF_FULL_LO, 16'h0000);
        rd("full_hi", cbt_pkg::OFF_FULL_HI, 16'h0000);
        rd("ovf_lo", cbt_pkg::OFF_OVF_LO, 16'h0000);
        rd("ovf_hi", cbt_pkg::OFF_OVF_HI, 16'h0000);
        rd("ctrl0", cbt_pkg::OFF_CTRL0, 16'h0000);
        apb(1'b0, 8'h40, 16'h0000);
        chk("unmapped_err", 1, e);
    endtask
    task automatic t_rx();
        apb(1'b1, cbt_pkg::OFF_MASK_SID, 16'hFFE3);
        apb(1'b1, cbt_pkg::OFF_MASK_EID, 16'hFFFF);
        rx(5'd9, FILT, 1'b1, 1'b0, 5'h07);
        chk("dma_buf", 9, dma_last.buf_idx);
        chk("sid_word", {FILT[28:18], 2'b01}, dma_last.sid_word);
        chk("stat_word", 16'h0700, dma_last.stat_word);
        rd("full_lo", cbt_pkg::OFF_FULL_LO, 16'h0200);
        rx(5'd9, FILT, 1'b1, 1'b0, 5'h03);
        chk("stat_kept", 16'h0700, dma_last.stat_word);
        rd("ovf_lo", cbt_pkg::OFF_OVF_LO, 16'h0200);
        rd("full_kept", cbt_pkg::OFF_FULL_LO, 16'h0200);
        rx(5'd20, FILT, 1'b0, 1'b1, 5'h02);
        chk("sid_rtr", {FILT[28:18], 2'b10}, dma_last.sid_word);
        rd("full_hi", cbt_pkg::OFF_FULL_HI, 16'h0010);
        apb(1'b1, cbt_pkg::OFF_FULL_LO, 16'hFDFF);
        apb(1'b1, cbt_pkg::OFF_OVF_LO, 16'hFFFF);
        rd("full_clr", cbt_pkg::OFF_FULL_LO, 16'h0000);
        rd("ovf_kept", cbt_pkg::OFF_OVF_LO, 16'h0200);
        apb(1'b1, cbt_pkg::OFF_OVF_LO, 16'h0000);
        rd("ovf_clr", cbt_pkg::OFF_OVF_LO, 16'h0000);
    endtask
    task automatic t_mask();
        apb(1'b1, cbt_pkg::OFF_MASK_EID, 16'h0001);
        rx(5'd12, FILT ^ 29'h1, 1'b1, 1'b0, 5'h00);
        rx(5'd13, FILT ^ 29'h2, 1'b1, 1'b0, 5'h00);
        rd("mask_eid", cbt_pkg::OFF_FULL_LO, 16'h2000);
        apb(1'b1, cbt_pkg::OFF_MASK_SID, 16'h7FE3);
        rx(5'd14, FILT ^ 29'h10000000, 1'b0, 1'b0, 5'h00);
        rd("mask_sid", cbt_pkg::OFF_FULL_LO, 16'h6000);
        apb(1'b1, cbt_pkg::OFF_FULL_LO, 16'h0000);
    endtask
    task automatic t_tx();
        apb(1'b1, cbt_pkg::OFF_CTRL0, 16'h898B);
        repeat (2) @(posedge pclk);
        chk("offer_pri", 4'b1000, tx_offer);
        txo(cbt_pkg::CBT_RES_ARB);
        rd("ctrl_arb", cbt_pkg::OFF_CTRL0, 16'h89AB);
        txo(cbt_pkg::CBT_RES_OK);
        rd("ctrl_ok", cbt_pkg::OFF_CTRL0, 16'h89A3);
        chk("offer_odd", 4'b1001, tx_offer);
        apb(1'b1, cbt_pkg::OFF_CTRL0, 16'h898B);
        rd("flags_clr", cbt_pkg::OFF_CTRL0, 16'h898B);
        apb(1'b1, cbt_pkg::OFF_CTRL0, 16'h818B);
        repeat (2) @(posedge pclk);
        chk("abort", 8'h02, abort_seen);
        txo(cbt_pkg::CBT_RES_ABT);
        rd("ctrl_abt", cbt_pkg::OFF_CTRL0, 16'h81C3);
        rd("offer_none", cbt_pkg::OFF_TX_STAT, 16'h0000);
    endtask
    task automatic t_rtr();
        apb(1'b1, cbt_pkg::OFF_CTRL0 + 8'h04, 16'h0084);
        rx(5'd2, FILT, 1'b1, 1'b1, 5'h00);
        rx(5'd3, FILT, 1'b1, 1'b1, 5'h00);
        rd("rtr_req", cbt_pkg::OFF_CTRL0 + 8'h04, 16'h008C);
        rd("dir_rx", cbt_pkg::OFF_FULL_LO, 16'h0008);
        chk("offer_rtr", 4'b1010, tx_offer);
    endtask
    task automatic t_lane();
        // Upper lane only: buffer 1 changes, buffer 0 keeps its byte
        pstrb <= 4'h2;
        apb(1'b1, cbt_pkg::OFF_CTRL0, 16'h8F8F);
        pstrb <= 4'h3;
        rd("ctrl_lane", cbt_pkg::OFF_CTRL0, 16'h8FC3);
        apb(1'b1, cbt_pkg::OFF_CTRL0, 16'h8F8F);
        rd("offer_tie", cbt_pkg::OFF_TX_STAT, 16'h0009);
        txo(cbt_pkg::CBT_RES_ERR);
        rd("ctrl_err", cbt_pkg::OFF_CTRL0, 16'h9F8F);
    endtask

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, rx_go, tx_go} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h3;
        rx_cmd = '1;
        tx_res = cbt_pkg::CBT_RES_OK;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rx();
        t_mask();
        t_tx();
        t_rtr();
        t_lane();
        final_report();
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule // can_buffer_status_and_tx_control_tb_top
